// >>> sfsf_pkg.sv
// package: constants for one channel of the synchronous fifo with status flags
package sfsf_pkg;
  localparam int DATA_W = 9;
  localparam int DEPTH = 256;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 9;
  localparam int OFS_W = 16;
  localparam int APB_AW = 8;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 9'h100;
  localparam logic [7:0] OFS_LO_RESET = 8'h07;
  localparam logic [7:0] OFS_HI_RESET = 8'h00;
  localparam logic [OFS_W-1:0] OFS_DEFAULT = 16'h0007;
  localparam logic [DATA_W-1:0] DOUT_RESET = 9'h000;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h00;
  localparam logic [APB_AW-1:0] REG_EMPTY_OFS = 8'h04;
  localparam logic [APB_AW-1:0] REG_FULL_OFS = 8'h08;
  localparam int ST_EMPTY_N = 0;
  localparam int ST_AEMPTY_N = 1;
  localparam int ST_AFULL_N = 2;
  localparam int ST_FULL_N = 3;
  localparam int ST_TWO_WE = 4;
  localparam int ST_SEQ_LSB = 5;
  localparam int ST_CNT_LSB = 8;
  typedef enum logic [1:0] {
    SFSF_EMPTY_LO = 2'b00,
    SFSF_EMPTY_HI = 2'b01,
    SFSF_FULL_LO = 2'b10,
    SFSF_FULL_HI = 2'b11
  } sfsf_ofs_sel_t;
endpackage

// >>> sfsf_mem.sv
// storage array of the fifo channel
`timescale 1ns/1ps
module sfsf_mem
(
  input wire logic CLK,
  input wire logic wr_en,
  input wire logic [sfsf_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [sfsf_pkg::DATA_W-1:0] wr_data,
  input wire logic [sfsf_pkg::ADDR_W-1:0] rd_addr,
  output logic [sfsf_pkg::DATA_W-1:0] rd_data
);
  import sfsf_pkg::*;

  logic [DATA_W-1:0] mem_q [DEPTH];

  always_ff @(posedge CLK)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_q[rd_addr];
endmodule

// >>> sfsf_top.sv
// fifo channel with status flags, offset loading and apb register access
`timescale 1ns/1ps
module sfsf_top
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [sfsf_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [sfsf_pkg::DATA_W-1:0] WRITE_DATA_IN,
  input wire logic WRITE_ENABLE_ONE_N,
  input wire logic WRITE_ENABLE_TWO_OR_LOAD,
  input wire logic READ_ENABLE_ONE_N,
  input wire logic READ_ENABLE_TWO_N,
  input wire logic OUTPUT_ENABLE_N,
  output logic [sfsf_pkg::DATA_W-1:0] READ_DATA_OUT,
  output logic READ_DATA_OUT_OE,
  output logic EMPTY_FLAG_N,
  output logic ALMOST_EMPTY_FLAG_N,
  output logic ALMOST_FULL_FLAG_N,
  output logic FULL_FLAG_N
);
  import sfsf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // flag decode for the next-state flags; the checks recompute it inline

  function automatic logic [3:0] flags_of(input logic [CNT_W-1:0] cnt,
                                          input logic [OFS_W-1:0] n_ofs,
                                          input logic [OFS_W-1:0] m_ofs);
    logic [OFS_W:0] wide;
    logic [OFS_W:0] sum;
    wide = {{(OFS_W+1-CNT_W){1'b0}}, cnt};
    sum = wide + {1'b0, m_ofs};
    // {full_n, almost_full_n, almost_empty_n, empty_n}
    flags_of[0] = (cnt != '0);
    flags_of[1] = (wide > {1'b0, n_ofs});
    flags_of[2] = (sum < {{(OFS_W+1-CNT_W){1'b0}}, DEPTH_CNT});
    flags_of[3] = (cnt != DEPTH_CNT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  logic two_we_q;
  logic [ADDR_W-1:0] wptr_q;
  logic [ADDR_W-1:0] wptr_d;
  logic [ADDR_W-1:0] rptr_q;
  logic [ADDR_W-1:0] rptr_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [7:0] e_lo_q;
  logic [7:0] e_hi_q;
  logic [7:0] f_lo_q;
  logic [7:0] f_hi_q;
  sfsf_ofs_sel_t seq_q;
  logic [DATA_W-1:0] dout_q;
  logic [3:0] flags_q;
  logic [3:0] flags_d;

  ////////////////////////////////////////////////////////////////////////
  // pin decode

  wire load_low = ~two_we_q & ~WRITE_ENABLE_TWO_OR_LOAD;
  wire we1 = ~WRITE_ENABLE_ONE_N;
  wire we_both = we1 & WRITE_ENABLE_TWO_OR_LOAD;
  wire re_both = ~READ_ENABLE_ONE_N & ~READ_ENABLE_TWO_N;
  wire full_now = (cnt_q == DEPTH_CNT);
  wire empty_now = (cnt_q == '0);
  wire do_wr = we_both & ~full_now;
  wire do_rd = re_both & ~load_low & ~empty_now;
  wire ofs_wr = load_low & we1;
  wire ofs_rd = load_low & re_both & ~ofs_wr;
  wire [OFS_W-1:0] n_prog = {e_hi_q, e_lo_q};
  wire [OFS_W-1:0] m_prog = {f_hi_q, f_lo_q};
  wire [OFS_W-1:0] n_ofs = two_we_q ? OFS_DEFAULT : n_prog;
  wire [OFS_W-1:0] m_ofs = two_we_q ? OFS_DEFAULT : m_prog;
  wire [DATA_W-1:0] mem_rd_data;
  wire [7:0] ofs_sel_byte =
    (seq_q == SFSF_EMPTY_LO) ? e_lo_q :
    (seq_q == SFSF_EMPTY_HI) ? e_hi_q :
    (seq_q == SFSF_FULL_LO) ? f_lo_q : f_hi_q;

  ////////////////////////////////////////////////////////////////////////
  // pointers, count and flags

  assign wptr_d = do_wr ? wptr_q + 8'h01 : wptr_q;
  assign rptr_d = do_rd ? rptr_q + 8'h01 : rptr_q;
  assign cnt_d = (do_wr && !do_rd) ? cnt_q + 9'h001 :
                 (do_rd && !do_wr) ? cnt_q - 9'h001 : cnt_q;
  // one count feeds every flag, so the flag pattern never tears
  assign flags_d = flags_of(cnt_d, n_ofs, m_ofs);

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      flags_q <= 4'hc;
    end
    else
    begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      flags_q <= flags_d;
    end
  end

  // the mode pin is sampled on every clocked edge while reset is held
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      two_we_q <= WRITE_ENABLE_TWO_OR_LOAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // offset registers: pin sequence has priority over the bus

  wire apb_wr = PSEL & PENABLE & PWRITE;
  wire apb_e_wr = apb_wr & (PADDR == REG_EMPTY_OFS) & ~two_we_q;
  wire apb_f_wr = apb_wr & (PADDR == REG_FULL_OFS) & ~two_we_q;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      e_lo_q <= OFS_LO_RESET;
      e_hi_q <= OFS_HI_RESET;
      f_lo_q <= OFS_LO_RESET;
      f_hi_q <= OFS_HI_RESET;
      seq_q <= SFSF_EMPTY_LO;
    end
    else if (ofs_wr)
    begin
      unique case (seq_q)
        SFSF_EMPTY_LO: e_lo_q <= WRITE_DATA_IN[7:0];
        SFSF_EMPTY_HI: e_hi_q <= WRITE_DATA_IN[7:0];
        SFSF_FULL_LO: f_lo_q <= WRITE_DATA_IN[7:0];
        SFSF_FULL_HI: f_hi_q <= WRITE_DATA_IN[7:0];
      endcase
      seq_q <= sfsf_ofs_sel_t'(seq_q + 2'b01);
    end
    else
    begin
      if (ofs_rd)
      begin
        seq_q <= sfsf_ofs_sel_t'(seq_q + 2'b01);
      end
      if (apb_e_wr)
      begin
        e_lo_q <= PWDATA[7:0];
        e_hi_q <= PWDATA[15:8];
      end
      if (apb_f_wr)
      begin
        f_lo_q <= PWDATA[7:0];
        f_hi_q <= PWDATA[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // storage and output register

  sfsf_mem u_mem
  (
    .CLK(CLK),
    .wr_en(do_wr),
    .wr_addr(wptr_q),
    .wr_data(WRITE_DATA_IN),
    .rd_addr(rptr_q),
    .rd_data(mem_rd_data)
  );

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      dout_q <= DOUT_RESET;
    end
    else if (do_rd)
    begin
      dout_q <= mem_rd_data;
    end
    else if (ofs_rd)
    begin
      dout_q <= {1'b0, ofs_sel_byte};
    end
  end

  assign READ_DATA_OUT = dout_q;
  assign READ_DATA_OUT_OE = ~OUTPUT_ENABLE_N;
  assign EMPTY_FLAG_N = flags_q[0];
  assign ALMOST_EMPTY_FLAG_N = flags_q[1];
  assign ALMOST_FULL_FLAG_N = flags_q[2];
  assign FULL_FLAG_N = flags_q[3];

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, error on unmapped address

  wire hit_status = (PADDR == REG_STATUS);
  wire hit_e = (PADDR == REG_EMPTY_OFS);
  wire hit_f = (PADDR == REG_FULL_OFS);
  wire hit_any = hit_status | hit_e | hit_f;
  wire [31:0] status_word = {15'h0000, cnt_q, 1'b0, seq_q, two_we_q,
                             flags_q};
  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_e ? {16'h0000, n_ofs} :
                       hit_f ? {16'h0000, m_ofs} : 32'h0000_0000;

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_any;
  assign PRDATA = (PSEL & PENABLE & ~PWRITE) ? rd_mux : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_empty_pattern: assert property (
    (cnt_q == '0) |-> (!EMPTY_FLAG_N && !ALMOST_EMPTY_FLAG_N &&
                       ALMOST_FULL_FLAG_N && FULL_FLAG_N))
    else $error("empty flag pattern wrong");

  a_full_pattern: assert property (
    (cnt_q == DEPTH_CNT) |-> (!FULL_FLAG_N && !ALMOST_FULL_FLAG_N &&
                              EMPTY_FLAG_N && ALMOST_EMPTY_FLAG_N))
    else $error("full flag pattern wrong");

  a_mid_pattern: assert property (
    ({7'h00, cnt_q} > n_ofs &&
     ({8'h00, cnt_q} + {1'b0, m_ofs}) < {8'h00, DEPTH_CNT} &&
     $stable(n_ofs) && $stable(m_ofs))
    |-> (&flags_q))
    else $error("middle range flags not all high");

  // flags lag an offset change by one edge, so offsets must hold for two
  a_af_assert_at: assert property (
    $fell(ALMOST_FULL_FLAG_N) && $stable(m_ofs) &&
    $past(m_ofs) == $past(m_ofs, 2) |->
      ({8'h00, cnt_q} + {1'b0, m_ofs}) >= {8'h00, DEPTH_CNT})
    else $error("almost-full asserted below threshold");

  a_ae_assert_at: assert property (
    $fell(ALMOST_EMPTY_FLAG_N) && $stable(n_ofs) &&
    $past(n_ofs) == $past(n_ofs, 2) |->
      {7'h00, cnt_q} <= n_ofs && $past(do_rd))
    else $error("almost-empty asserted outside threshold");

  a_af_release: assert property (
    $rose(ALMOST_FULL_FLAG_N) && $stable(m_ofs) &&
    $past(m_ofs) == $past(m_ofs, 2) |->
      ({8'h00, cnt_q} + {1'b0, m_ofs}) < {8'h00, DEPTH_CNT} && $past(do_rd))
    else $error("almost-full released outside threshold");

  a_ae_release: assert property (
    $rose(ALMOST_EMPTY_FLAG_N) && $stable(n_ofs) &&
    $past(n_ofs) == $past(n_ofs, 2) |->
      {7'h00, cnt_q} > n_ofs && $past(do_wr))
    else $error("almost-empty released outside threshold");

  a_count_ptrs: assert property (
    cnt_q[ADDR_W-1:0] == wptr_q - rptr_q)
    else $error("word count disagrees with pointers");

  a_count_step: assert property (
    do_wr && !do_rd |=> cnt_q == $past(cnt_q) + 9'h001)
    else $error("accepted write did not add a word");

  a_mode_hold: assert property (
    !$past(SRST) |-> $stable(two_we_q))
    else $error("pin mode changed outside reset");

  a_ofs_readback: assert property (
    ofs_rd |=> READ_DATA_OUT == {1'b0, $past(ofs_sel_byte)})
    else $error("offset readback wrong");

  a_no_wr_full: assert property (
    full_now && we_both |=> $stable(wptr_q) && FULL_FLAG_N == $past(do_rd))
    else $error("write accepted while full");

  a_no_rd_empty: assert property (
    empty_now && re_both |=> $stable(rptr_q) && EMPTY_FLAG_N == $past(do_wr))
    else $error("read accepted while empty");

  a_single_we: assert property (
    !(we1 && WRITE_ENABLE_TWO_OR_LOAD) |=> $stable(wptr_q))
    else $error("write without both enables");

  a_dout_hold: assert property (
    !re_both |=> $stable(READ_DATA_OUT))
    else $error("output changed without read");

  a_default_ofs: assert property (
    two_we_q |->
      ALMOST_EMPTY_FLAG_N == ({7'h00, cnt_q} > OFS_DEFAULT) &&
      ALMOST_FULL_FLAG_N ==
        ({7'h00, cnt_q} + OFS_DEFAULT < {7'h00, DEPTH_CNT}))
    else $error("default offsets not used");

  a_seq_wrap: assert property (
    ofs_wr && seq_q == SFSF_FULL_HI |=> seq_q == SFSF_EMPTY_LO)
    else $error("offset sequence did not wrap");

  a_reset_out: assert property (
    $fell(SRST) |-> READ_DATA_OUT == DOUT_RESET)
    else $error("output not low after reset");
endmodule

// >>> sfsf_peer.sv
// far-side model: writer and reader control logic driving the channel
`timescale 1ns/1ps
module sfsf_peer
(
  input wire logic CLK,
  input wire logic go_wr,
  input wire logic go_rd,
  input wire logic half,
  input wire logic pin_low,
  input wire logic [7:0] ld_byte,
  input wire logic full_n,
  output logic we_one_n,
  output logic we_two_ld,
  output logic re_one_n,
  output logic re_two_n,
  output logic [sfsf_pkg::DATA_W-1:0] wdata
);
  import sfsf_pkg::*;
  logic [DATA_W-1:0] cnt_q = '0;
  assign we_one_n = ~go_wr;
  // pin level is held through reset to pick the mode
  assign we_two_ld = ~pin_low;
  assign re_one_n = ~go_rd;
  assign re_two_n = ~(go_rd & ~half);
  assign wdata = pin_low ? {1'b0, ld_byte} : cnt_q;
  // composite full flag of a width-expanded pair; one channel here
  wire all_full_n = full_n;
  // next stream word only once the channel took the last one
  always_ff @(posedge CLK)
  begin
    if (go_wr && !pin_low && all_full_n)
      cnt_q <= cnt_q + 1'b1;
  end
endmodule

// >>> sfsf_top_tb.sv
// self-checking bench for the fifo channel flags, modes and registers
`timescale 1ns/1ps
module sfsf_top_tb;
  import sfsf_pkg::*;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, go_wr = 1'b0, go_rd = 1'b0, half = 1'b0;
  logic pin_low = 1'b0, oe_n = 1'b0, pready, pslverr, err, rdata_oe;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] ld_byte = '0;
  logic [DATA_W-1:0] wdata, rdata;
  logic we1_n, we2_ld, re1_n, re2_n, ef_n, aef_n, afl_n, ff_n;
  logic [7:0] lb [5] = '{8'h05, 8'h00, 8'h04, 8'h00, 8'h02};
  // rows: word count, then {full, almost full, almost empty, empty}
  logic [12:0] rows [8] = '{{9'd0, 4'hc}, {9'd1, 4'hd}, {9'd7, 4'hd},
    {9'd8, 4'hf}, {9'd248, 4'hf}, {9'd249, 4'hb}, {9'd255, 4'hb},
    {9'd256, 4'h3}};
  int miscompares = 0, tests_run = 0, cyc = 0, cur = 0;
  wire [3:0] flags = {ff_n, afl_n, aef_n, ef_n};

  always #10 clk = ~clk;

  sfsf_peer peer (.CLK(clk), .go_wr(go_wr), .go_rd(go_rd), .half(half),
    .pin_low(pin_low), .ld_byte(ld_byte), .full_n(ff_n),
    .we_one_n(we1_n), .we_two_ld(we2_ld), .re_one_n(re1_n),
    .re_two_n(re2_n), .wdata(wdata));

  sfsf_top DUT (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WRITE_DATA_IN(wdata),
    .WRITE_ENABLE_ONE_N(we1_n), .WRITE_ENABLE_TWO_OR_LOAD(we2_ld),
    .READ_ENABLE_ONE_N(re1_n), .READ_ENABLE_TWO_N(re2_n),
    .OUTPUT_ENABLE_N(oe_n), .READ_DATA_OUT(rdata),
    .READ_DATA_OUT_OE(rdata_oe), .EMPTY_FLAG_N(ef_n),
    .ALMOST_EMPTY_FLAG_N(aef_n), .ALMOST_FULL_FLAG_N(afl_n),
    .FULL_FLAG_N(ff_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic push(input int n);
    if (n > 0)
    begin
      go_wr <= 1'b1;
      repeat (n) @(posedge clk);
      go_wr <= 1'b0;
    end
  endtask

  // n reads; word i of the stream is expected to equal base plus i
  task automatic pop(input int n, input int base);
    go_rd <= 1'b1;
    for (int i = 0; i <= n; i++)
    begin
      @(posedge clk);
      if (i == n - 1)
        go_rd <= 1'b0;
      if (i > 0)
        chk("rdata", rdata, 9'(base + i - 1));
    end
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      test_done();
    end
  end

  initial
  begin
    do_reset();
    chk("dout_reset", rdata, 32'h0);
    chk("dout_oe", rdata_oe, 32'h1);
    oe_n <= 1'b1;
    @(posedge clk);
    chk("dout_oe_off", rdata_oe, 32'h0);
    oe_n <= 1'b0;
    for (int r = 0; r < 8; r++)
    begin
      push(int'(rows[r][12:4]) - cur);
      cur = int'(rows[r][12:4]);
      @(posedge clk);
      chk("flags", flags, rows[r][3:0]);
    end
    // writes while full must be dropped
    push(2);
    @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", {rd[16:8], rd[4:0]}, {9'h100, 5'h13});
    apb(1'b1, REG_EMPTY_OFS, 32'h3);
    apb(1'b0, REG_EMPTY_OFS, 32'h0);
    chk("ofs_default", rd, 32'h7);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    chk("pready", pready, 32'h1);
    pop(256, 0);
    chk("drained", flags, 4'hc);
    // reads while empty must leave the output alone
    go_rd <= 1'b1;
    repeat (2) @(posedge clk);
    go_rd <= 1'b0;
    @(posedge clk);
    chk("hold_empty", rdata, 32'h0ff);
    pin_low <= 1'b1;
    push(2);
    pin_low <= 1'b0;
    @(posedge clk);
    chk("we_two_off", flags, 4'hc);
    push(1);
    half <= 1'b1;
    go_rd <= 1'b1;
    repeat (2) @(posedge clk);
    go_rd <= 1'b0;
    half <= 1'b0;
    @(posedge clk);
    chk("half_rd", rdata, 32'h0ff);
    chk("half_rd_flags", flags, 4'hd);
    // second reset with a word stored, pin low selects load mode
    pin_low <= 1'b1;
    do_reset();
    chk("rst2_flags", flags, 4'hc);
    chk("rst2_dout", rdata, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      ld_byte <= lb[i];
      go_wr <= 1'b1;
      @(posedge clk);
    end
    go_wr <= 1'b0;
    // pin readback walks on from the empty high byte
    go_rd <= 1'b1;
    repeat (2) @(posedge clk);
    go_rd <= 1'b0;
    pin_low <= 1'b0;
    @(posedge clk);
    chk("ofs_readback", rdata, 32'h004);
    apb(1'b0, REG_EMPTY_OFS, 32'h0);
    chk("ofs_empty", rd, 32'h2);
    apb(1'b0, REG_FULL_OFS, 32'h0);
    chk("ofs_full", rd, 32'h4);
    apb(1'b1, REG_FULL_OFS, 32'h0000_0006);
    apb(1'b0, REG_FULL_OFS, 32'h0);
    chk("ofs_full_bus", rd, 32'h6);
    push(2);
    @(posedge clk);
    chk("n_words", flags, 4'hd);
    push(1);
    @(posedge clk);
    chk("n_plus_one", flags, 4'hf);
    test_done();
  end
endmodule
